// ---- logic/pcc_pkg.sv ----
package pcc_pkg;

  // Block dimensions.
  localparam int NUM_APLL = 3;
  localparam int NUM_POST = 5;
  localparam int NUM_OUT  = 16;
  localparam int NUM_REF  = 2;

  // Clock rate and timing figures.
  localparam int CLK_MHZ     = 25;
  localparam int CAL_TIME_US = 100;
  localparam int CAL_CYC     = CAL_TIME_US * CLK_MHZ;
  localparam int XO_WIN_NS   = 1000;
  localparam int XO_WIN_CYC  = XO_WIN_NS * CLK_MHZ / 1000;

  // Legal post-divider ranges per analog loop.
  localparam logic [3:0] A1_P_MIN  = 4'h2;
  localparam logic [3:0] A1_P_MAX  = 4'h7;
  localparam logic [3:0] A2_P1_MIN = 4'h2;
  localparam logic [3:0] A2_P1_MAX = 4'hD;
  localparam logic [3:0] A2_P2_MIN = 4'h2;
  localparam logic [3:0] A2_P2_MAX = 4'h3;
  localparam logic [3:0] A3_P_MIN  = 4'h1;
  localparam logic [3:0] A3_P_MAX  = 4'h7;

  // Output routing masks per post-divider clock and the SYSREF stage mask, bit n is output n.
  localparam logic [15:0] ROUTE_A1P1  = 16'hC00F;
  localparam logic [15:0] ROUTE_A1P2  = 16'h000F;
  localparam logic [15:0] ROUTE_A2P1  = 16'hFFFF;
  localparam logic [15:0] ROUTE_A2P2  = 16'h0050;
  localparam logic [15:0] ROUTE_A3    = 16'hFFF3;
  localparam logic [15:0] SYSREF_MASK = 16'h3FF3;

  // Denominator constants.
  localparam logic [40:0] FIXED_DEN = 41'h100_0000_0000;

  // Layout of the synchronised pin bus.
  localparam int SY_XO   = 0;
  localparam int SY_REF  = 1;
  localparam int SY_VCO  = 3;
  localparam int SY_LOCK = 6;
  localparam int SY_W    = 9;

  typedef enum logic [2:0] {
    SRC_A1P1 = 3'h0,
    SRC_A1P2 = 3'h1,
    SRC_A2P1 = 3'h2,
    SRC_A2P2 = 3'h3,
    SRC_A3   = 3'h4
  } pcc_src_t;

  typedef enum logic [2:0] {
    CS_OFF     = 3'h0,
    CS_WAIT_XO = 3'h1,
    CS_CAL     = 3'h2,
    CS_LOCK    = 3'h3,
    CS_READY   = 3'h4
  } pcc_cal_t;

  typedef struct packed {
    logic        analog_loop_enable;
    logic        ref_vco3;
    logic        dbl_en;
    logic [4:0]  r_div;
    logic [11:0] n_int;
    logic [39:0] n_num;
    logic        den_prog;
    logic [23:0] n_den;
    logic [3:0]  primary_post_divider;
    logic [3:0]  secondary_post_divider;
    logic        dpll_steer;
  } pcc_apll_cfg_t;

  typedef struct packed {
    pcc_src_t    src;
    logic [11:0] output_channel_divider;
    logic        bypass;
    logic        sysref_en;
    logic [19:0] sysref_div;
    logic        mute_en;
  } pcc_out_cfg_t;

  typedef struct packed {
    logic [1:0][32:0] fb_int;
    logic [1:0][39:0] fb_num;
    logic [1:0][39:0] fb_den;
    logic [1:0]       feedback_setting_select;
    logic             ref_sel;
    logic [1:0][15:0] ref_div;
    logic [1:0]       fb_apll;
  } pcc_dpll_cfg_t;

endpackage

// ---- logic/pcc_div.sv ----
`timescale 1ns/100ps
// Tick divider: one output tick per div_int (or div_int + 1) input ticks.
// A value of 0 or 1 passes every tick, which doubles as bypass.
module pcc_div #(
  parameter int IW = 12,
  parameter int FW = 1
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          tick_in,
  input  wire logic [IW-1:0] div_int,
  input  wire logic [FW-1:0] frac_num,
  input  wire logic [FW:0]   frac_den,
  input  wire logic          frac_en,
  output logic               tick_out
);

  logic [IW-1:0] cnt_r;
  logic [IW:0]   lim_r;
  logic [FW-1:0] acc_r;
  logic [FW:0]   sum;
  logic          wrap;
  logic          reach;

  // Accumulator carry stretches the next period by one input tick.
  assign sum   = {1'b0, acc_r} + {1'b0, frac_num};
  assign wrap  = frac_en && (sum >= frac_den);
  assign reach = ({1'b0, cnt_r} + {{IW{1'b0}}, 1'b1}) >= lim_r;

  // Count input ticks and reload the period on each output tick.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r    <= '0;
      lim_r    <= '0;
      acc_r    <= '0;
      tick_out <= 1'b0;
    end else if (ce) begin
      tick_out <= tick_in && reach;
      if (tick_in) begin
        if (reach) begin
          cnt_r <= '0;
          lim_r <= {1'b0, div_int} + {{IW{1'b0}}, wrap};
          if (!frac_en)
            acc_r <= '0;
          else if (wrap)
            acc_r <= FW'(sum - frac_den);
          else
            acc_r <= sum[FW-1:0];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end
endmodule

// ---- logic/pcc_top.sv ----
`timescale 1ns/100ps
module pcc_top (
  input  wire logic                                mclk,
  input  wire logic                                rst,
  input  wire logic                                ce,
  input  wire logic                                xo_in,
  input  wire logic [1:0]                          ref_in,
  input  wire logic [2:0]                          vco_clk,
  input  wire logic [2:0]                          apll_lock_in,
  input  wire pcc_pkg::pcc_apll_cfg_t [2:0]        apll_cfg,
  input  wire pcc_pkg::pcc_out_cfg_t [15:0]        out_cfg,
  input  wire pcc_pkg::pcc_dpll_cfg_t              dpll_cfg,
  output logic [15:0]                              out_tick,
  output logic [15:0]                              out_muted,
  output logic [2:0]                               apll_ready,
  output logic [2:0]                               apll_pfd_tick,
  output logic [2:0]                               apll_fb_tick,
  output logic [2:0][39:0]                         sdm_num,
  output logic [15:0]                              tdc_word,
  output logic                                     tdc_valid,
  output logic                                     dpll_fb_tick,
  output logic                                     xo_detected
);

  localparam int NA = pcc_pkg::NUM_APLL;
  localparam int NP = pcc_pkg::NUM_POST;
  localparam int NO = pcc_pkg::NUM_OUT;
  localparam int NR = pcc_pkg::NUM_REF;
  localparam int SW = pcc_pkg::SY_W;

  // Clamp a post-divider value into its legal range.
  function automatic logic [3:0] clamp_p(input logic [3:0] v,
                                         input logic [3:0] lo,
                                         input logic [3:0] hi);
    if (v < lo)
      clamp_p = lo;
    else if (v > hi)
      clamp_p = hi;
    else
      clamp_p = v;
  endfunction

  // Route mask of a source code; illegal codes reach nothing.
  function automatic logic [15:0] route_of(input pcc_pkg::pcc_src_t s);
    unique case (s)
      pcc_pkg::SRC_A1P1: route_of = pcc_pkg::ROUTE_A1P1;
      pcc_pkg::SRC_A1P2: route_of = pcc_pkg::ROUTE_A1P2;
      pcc_pkg::SRC_A2P1: route_of = pcc_pkg::ROUTE_A2P1;
      pcc_pkg::SRC_A2P2: route_of = pcc_pkg::ROUTE_A2P2;
      pcc_pkg::SRC_A3:   route_of = pcc_pkg::ROUTE_A3;
      default:           route_of = 16'h0000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers; the second and third stages feed edge detection.
  logic [SW-1:0] sy1_r;
  logic [SW-1:0] sy2_r;
  logic [SW-1:0] sy3_r;
  logic [SW-1:0] rise;
  logic [SW-1:0] fall;

  // Every pin crosses two flops before any logic looks at it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
    end else if (ce) begin
      sy1_r <= {apll_lock_in, vco_clk, ref_in, xo_in};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  assign rise = sy2_r & ~sy3_r;
  assign fall = ~sy2_r & sy3_r;

  logic [2:0] vco_tick;
  logic [2:0] lock_s;
  assign vco_tick = rise[pcc_pkg::SY_VCO +: 3];
  assign lock_s   = sy2_r[pcc_pkg::SY_LOCK +: 3];

  // ---------------------------------------------------------------
  // XO activity monitor: present while a rising edge came within the window.
  logic [15:0] xo_win_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xo_win_r    <= '0;
      xo_detected <= 1'b0;
    end else if (ce) begin
      if (rise[pcc_pkg::SY_XO]) begin
        xo_win_r    <= 16'(pcc_pkg::XO_WIN_CYC);
        xo_detected <= 1'b1;
      end else if (xo_win_r != 16'h0000) begin
        xo_win_r <= xo_win_r - 16'h0001;
      end else begin
        xo_detected <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Post-dividers. Out-of-range settings are clamped rather than
  // passed on, so a bad write never yields an illegal ratio.
  logic [NP-1:0][3:0] post_val;
  logic [NP-1:0]      post_in;
  logic [NP-1:0]      post_tick;

  always_comb begin
    post_val[0] = clamp_p(apll_cfg[0].primary_post_divider,
                          pcc_pkg::A1_P_MIN, pcc_pkg::A1_P_MAX);
    post_val[1] = clamp_p(apll_cfg[0].secondary_post_divider,
                          pcc_pkg::A1_P_MIN, pcc_pkg::A1_P_MAX);
    post_val[2] = clamp_p(apll_cfg[1].primary_post_divider,
                          pcc_pkg::A2_P1_MIN, pcc_pkg::A2_P1_MAX);
    post_val[3] = clamp_p(apll_cfg[1].secondary_post_divider,
                          pcc_pkg::A2_P2_MIN, pcc_pkg::A2_P2_MAX);
    post_val[4] = clamp_p(apll_cfg[2].primary_post_divider,
                          pcc_pkg::A3_P_MIN, pcc_pkg::A3_P_MAX);
    post_in = {vco_tick[2], vco_tick[1], vco_tick[1],
               vco_tick[0], vco_tick[0]};
  end

  // One independent divider per post clock.
  for (genvar p = 0; p < NP; p++) begin : g_post
    pcc_div #(.IW(4), .FW(1)) u_post (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (post_in[p]),
      .div_int  (post_val[p]),
      .frac_num (1'h0),
      .frac_den (2'h1),
      .frac_en  (1'b0),
      .tick_out (post_tick[p])
    );
  end

  // ---------------------------------------------------------------
  // Digital loop: reference dividers, feedback divider, comparator.
  logic [NR-1:0] ref_div_tick;
  logic          tdc_ref_tick;
  logic          fb_set;
  logic [1:0]    fb_src;
  logic [40:0]   fb_den;

  for (genvar r = 0; r < NR; r++) begin : g_ref
    pcc_div #(.IW(16), .FW(1)) u_rdiv (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (rise[pcc_pkg::SY_REF + r]),
      .div_int  (dpll_cfg.ref_div[r]),
      .frac_num (1'h0),
      .frac_den (2'h1),
      .frac_en  (1'b0),
      .tick_out (ref_div_tick[r])
    );
  end

  // The selected reference's divided clock sets the comparator rate.
  assign tdc_ref_tick = ref_div_tick[dpll_cfg.ref_sel];
  assign fb_set = dpll_cfg.feedback_setting_select[dpll_cfg.ref_sel];
  assign fb_src = (dpll_cfg.fb_apll > 2'h2) ? 2'h2 : dpll_cfg.fb_apll;
  // A zero denominator field stands for the full 2^40.
  assign fb_den = (dpll_cfg.fb_den[fb_set] == 40'h0) ?
                  pcc_pkg::FIXED_DEN :
                  {1'b0, dpll_cfg.fb_den[fb_set]};

  pcc_div #(.IW(33), .FW(40)) u_dfb (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .tick_in  (vco_tick[fb_src]),
    .div_int  (dpll_cfg.fb_int[fb_set]),
    .frac_num (dpll_cfg.fb_num[fb_set]),
    .frac_den (fb_den),
    .frac_en  (1'b1),
    .tick_out (dpll_fb_tick)
  );

  // Phase comparator: counts reference ahead of feedback. The word
  // saturates so a lost reference cannot wrap the error sign.
  logic signed [15:0] phase_r;
  logic signed [15:0] phase_nxt;

  always_comb begin
    phase_nxt = phase_r;
    if (tdc_ref_tick && !dpll_fb_tick && phase_r != 16'sh7FFF)
      phase_nxt = phase_r + 16'sh0001;
    else if (dpll_fb_tick && !tdc_ref_tick && phase_r != -16'sh7FFF)
      phase_nxt = phase_r - 16'sh0001;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r   <= '0;
      tdc_word  <= '0;
      tdc_valid <= 1'b0;
    end else if (ce) begin
      phase_r   <= phase_nxt;
      tdc_valid <= tdc_ref_tick;
      if (tdc_ref_tick)
        tdc_word <= phase_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Analog loops: reference path, feedback divider, calibration.
  pcc_pkg::pcc_cal_t [NA-1:0] cal_r;

  for (genvar a = 0; a < NA; a++) begin : g_apll
    logic        xo_tick;
    logic        ref_tick;
    logic [40:0] n_den;
    logic        en_d_r;
    logic        en_rise;
    logic [15:0] cal_cnt_r;

    // Doubler takes both XO edges, giving twice the compare rate.
    assign xo_tick = apll_cfg[a].dbl_en ?
                     (rise[pcc_pkg::SY_XO] | fall[pcc_pkg::SY_XO]) :
                     rise[pcc_pkg::SY_XO];
    if (a < 2) begin : g_casc
      assign ref_tick = apll_cfg[a].ref_vco3 ? vco_tick[2] :
                        xo_tick;
    end else begin : g_xo
      assign ref_tick = xo_tick;
    end

    pcc_div #(.IW(5), .FW(1)) u_rdiv (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (ref_tick),
      .div_int  (apll_cfg[a].r_div),
      .frac_num (1'h0),
      .frac_den (2'h1),
      .frac_en  (1'b0),
      .tick_out (apll_pfd_tick[a])
    );

    // Modulator numerator, nudged by the digital loop when steered.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst)
        sdm_num[a] <= '0;
      else if (ce) begin
        if (apll_cfg[a].dpll_steer)
          sdm_num[a] <= apll_cfg[a].n_num +
                        {{24{tdc_word[15]}}, tdc_word};
        else
          sdm_num[a] <= apll_cfg[a].n_num;
      end
    end

    // Fixed 2^40 or programmable 24-bit denominator.
    assign n_den = apll_cfg[a].den_prog ?
                   {17'h0_0000, apll_cfg[a].n_den} :
                   pcc_pkg::FIXED_DEN;

    pcc_div #(.IW(12), .FW(40)) u_ndiv (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (vco_tick[a]),
      .div_int  (apll_cfg[a].n_int),
      .frac_num (sdm_num[a]),
      .frac_den (n_den),
      .frac_en  (1'b1),
      .tick_out (apll_fb_tick[a])
    );

    assign en_rise = apll_cfg[a].analog_loop_enable && !en_d_r;

    // Calibration sequencer. Reset lands in the XO wait so start-up
    // calibration needs no software action; the XO must be seen first
    // because a calibration on a missing clock would leave no lock.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cal_r[a]      <= pcc_pkg::CS_WAIT_XO;
        cal_cnt_r     <= '0;
        en_d_r        <= 1'b0;
        apll_ready[a] <= 1'b0;
      end else if (ce) begin
        en_d_r        <= apll_cfg[a].analog_loop_enable;
        apll_ready[a] <= 1'b0;
        if (!apll_cfg[a].analog_loop_enable) begin
          cal_r[a] <= pcc_pkg::CS_OFF;
        end else if (en_rise && cal_r[a] != pcc_pkg::CS_WAIT_XO) begin
          cal_r[a] <= pcc_pkg::CS_WAIT_XO;
        end else begin
          unique case (cal_r[a])
            pcc_pkg::CS_OFF: cal_r[a] <= pcc_pkg::CS_OFF;
            pcc_pkg::CS_WAIT_XO: begin
              if (xo_detected) begin
                cal_r[a]  <= pcc_pkg::CS_CAL;
                cal_cnt_r <= 16'(pcc_pkg::CAL_CYC - 1);
              end
            end
            pcc_pkg::CS_CAL: begin
              if (cal_cnt_r == 16'h0000)
                cal_r[a] <= pcc_pkg::CS_LOCK;
              else
                cal_cnt_r <= cal_cnt_r - 16'h0001;
            end
            pcc_pkg::CS_LOCK: begin
              if (lock_s[a]) begin
                cal_r[a]      <= pcc_pkg::CS_READY;
                apll_ready[a] <= 1'b1;
              end
            end
            pcc_pkg::CS_READY: apll_ready[a] <= 1'b1;
            default: cal_r[a] <= pcc_pkg::CS_OFF;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Output channels: source select, channel divider, SYSREF divider.
  for (genvar o = 0; o < NO; o++) begin : g_out
    logic        src_tick;
    logic        src_ok;
    logic        src_ready;
    logic        od_tick;
    logic        sr_tick;
    logic [11:0] od_val;
    logic        use_sr;
    logic [15:0] route_ok;

    // A source that may not reach this channel delivers no ticks.
    assign route_ok = route_of(out_cfg[o].src);
    assign src_ok   = route_ok[o];
    assign src_tick = src_ok && (out_cfg[o].src <= pcc_pkg::SRC_A3) &&
                      post_tick[out_cfg[o].src];
    assign src_ready = (out_cfg[o].src <= pcc_pkg::SRC_A1P2) ?
                       apll_ready[0] :
                       (out_cfg[o].src <= pcc_pkg::SRC_A2P2) ?
                       apll_ready[1] :
                       (out_cfg[o].src == pcc_pkg::SRC_A3) &&
                       apll_ready[2];
    assign od_val = out_cfg[o].bypass ? 12'h001 :
                    out_cfg[o].output_channel_divider;

    pcc_div #(.IW(12), .FW(1)) u_od (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (src_tick),
      .div_int  (od_val),
      .frac_num (1'h0),
      .frac_den (2'h1),
      .frac_en  (1'b0),
      .tick_out (od_tick)
    );

    pcc_div #(.IW(20), .FW(1)) u_sr (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .tick_in  (od_tick),
      .div_int  (out_cfg[o].sysref_div),
      .frac_num (1'h0),
      .frac_den (2'h1),
      .frac_en  (1'b0),
      .tick_out (sr_tick)
    );

    // Channels without the SYSREF stage ignore its enable.
    assign use_sr = out_cfg[o].sysref_en &&
                    pcc_pkg::SYSREF_MASK[o];

    // With mute_en set, mute holds until the feeding loop is calibrated and locked.
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        out_muted[o] <= 1'b1;
        out_tick[o]  <= 1'b0;
      end else if (ce) begin
        out_muted[o] <= out_cfg[o].mute_en && !src_ready;
        out_tick[o]  <= !out_muted[o] &&
                        (use_sr ? sr_tick : od_tick);
      end
    end
  end
endmodule

// ---- tb/pcc_top_sva.sv ----
`timescale 1ns/100ps
// Pin-level checker; helpers rebuild routing and mute wants on their own.
module pcc_top_sva (
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         ce,
  input wire logic                         xo_in,
  input wire pcc_pkg::pcc_apll_cfg_t [2:0] apll_cfg,
  input wire pcc_pkg::pcc_out_cfg_t [15:0] out_cfg,
  input wire logic [15:0]                  out_tick,
  input wire logic [15:0]                  out_muted,
  input wire logic [2:0]                   apll_ready,
  input wire logic [2:0][39:0]             sdm_num,
  input wire logic [15:0]                  tdc_word,
  input wire logic                         tdc_valid,
  input wire logic                         xo_detected
);
  logic [15:0]      ok;
  logic [15:0]      want;
  logic [39:0]      exp0;
  logic [1:0]       alive_r;
  logic [5:0]       quiet_r;
  logic             xo_r;
  logic [2:0]       prev_r;
  logic [2:0]       long_en;
  logic [2:0][11:0] en_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Legal routes per source; src bits 2:1 name the analog loop.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      case (out_cfg[i].src)
        pcc_pkg::SRC_A1P1: ok[i] = pcc_pkg::ROUTE_A1P1[i];
        pcc_pkg::SRC_A1P2: ok[i] = pcc_pkg::ROUTE_A1P2[i];
        pcc_pkg::SRC_A2P1: ok[i] = 1'b1;
        pcc_pkg::SRC_A2P2: ok[i] = pcc_pkg::ROUTE_A2P2[i];
        pcc_pkg::SRC_A3:   ok[i] = pcc_pkg::ROUTE_A3[i];
        default:           ok[i] = 1'b0;
      endcase
      want[i] = out_cfg[i].mute_en & ~apll_ready[out_cfg[i].src[2:1]];
    end
    for (int k = 0; k < 3; k++) long_en[k] = en_r[k] >= 12'h9C4;
  end
  assign exp0 = apll_cfg[0].dpll_steer
              ? apll_cfg[0].n_num + {{24{tdc_word[15]}}, tdc_word}
              : apll_cfg[0].n_num;
  // Ages since reset, XO change and enable rise; counters saturate.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alive_r <= 2'h0;
      quiet_r <= 6'h0;
      xo_r    <= 1'b0;
      prev_r  <= 3'h0;
      en_r    <= '0;
    end else begin
      alive_r <= {alive_r[0], 1'b1};
      xo_r    <= xo_in;
      quiet_r <= (xo_in != xo_r) ? 6'h0 : quiet_r + {5'h0, quiet_r != 6'h3F};
      prev_r  <= apll_ready;
      for (int k = 0; k < 3; k++)
        en_r[k] <= !apll_cfg[k].analog_loop_enable ? 12'h0
                 : en_r[k] + {11'h0, en_r[k] != 12'hFFF};
    end
  end
  property p_mute_gate;
    (out_tick & $past(out_muted)) == 16'h0;
  endproperty
  a_mute_gate: assert property (p_mute_gate) else $error("tick while muted");
  property p_route;
    (out_tick & ~ok & ~$past(ok) & ~$past(ok, 2) & ~$past(ok, 3)) == 16'h0;
  endproperty
  a_route: assert property (p_route) else $error("tick on bad route");
  property p_mute_lvl;
    alive_r[1] && $past(ce) |-> out_muted == $past(want);
  endproperty
  a_mute_lvl: assert property (p_mute_lvl) else $error("mute level wrong");
  property p_xo_lost;
    quiet_r > 6'h28 |-> !xo_detected;
  endproperty
  a_xo_lost: assert property (p_xo_lost) else $error("stale xo detect");
  property p_cal_len;
    (apll_ready & ~prev_r & ~long_en) == 3'h0;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("ready too early");
  property p_off;
    (!apll_cfg[0].analog_loop_enable) [*3] |-> !apll_ready[0];
  endproperty
  a_off: assert property (p_off) else $error("ready while off");
  property p_steer;
    alive_r[1] && $past(ce) |-> sdm_num[0] == $past(exp0);
  endproperty
  a_steer: assert property (p_steer) else $error("steer sum wrong");
  property p_tdc_hold;
    !tdc_valid |-> $stable(tdc_word);
  endproperty
  a_tdc_hold: assert property (p_tdc_hold) else $error("word moved");
  property p_freeze;
    !ce |=> $stable(out_muted) && $stable(apll_ready);
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved while held");
  c_ready: cover property ($rose(apll_ready[1]));
  c_valid: cover property (tdc_valid);
  c_tick: cover property (out_tick[0]);
endmodule

bind pcc_top pcc_top_sva u_sva (
  .mclk, .rst, .ce, .xo_in, .apll_cfg, .out_cfg, .out_tick, .out_muted,
  .apll_ready, .sdm_num, .tdc_word, .tdc_valid, .xo_detected
);

// ---- tb/pcc_src_model.sv ----
`timescale 1ns/100ps
// Clock sources: XO, two references and three VCOs, toggled from mclk so
// that tick spacing is exact; a stopped XO rests at its level.
module pcc_src_model (
  input  wire logic  mclk,
  input  wire logic  xo_run,
  input  wire logic  lock_ok,
  output logic       xo_in,
  output logic [1:0] ref_in,
  output logic [2:0] vco_clk,
  output logic [2:0] apll_lock_in
);
  int n = 0;
  // Pins move on the falling edge, well away from the sampling edge.
  always @(negedge mclk) begin
    n <= n + 1;
    if (xo_run && n % 4 == 0) xo_in <= ~xo_in;
    if (n % 2 == 0) vco_clk <= ~vco_clk;
    if (n % 3 == 0) ref_in <= ~ref_in;
  end
  initial begin
    xo_in = 1'b0;
    ref_in = 2'h0;
    vco_clk = 3'h0;
  end
  assign apll_lock_in = {3{lock_ok}};
endmodule

// ---- tb/tb_pcc_top.sv ----
`timescale 1ns/100ps
module tb_pcc_top;
  logic                         mclk = 1'b0;
  logic                         rst = 1'b1;
  logic                         ce = 1'b1;
  logic                         xo_run = 1'b0;
  logic                         xo_in;
  logic                         tdc_valid;
  logic                         dfb;
  logic [1:0]                   ref_in;
  logic [2:0]                   vco_clk;
  logic [2:0]                   lock_in;
  logic [2:0]                   apll_ready;
  logic [2:0]                   fbt;
  logic [2:0]                   pfd;
  logic [2:0][39:0]             sdm_num;
  logic [15:0]                  out_tick;
  logic [15:0]                  out_muted;
  logic [15:0]                  tdc_word;
  pcc_pkg::pcc_apll_cfg_t [2:0] acfg;
  pcc_pkg::pcc_out_cfg_t [15:0] ocfg;
  pcc_pkg::pcc_dpll_cfg_t       dcfg;
  wire  [23:0]                  probe = {pfd, fbt, dfb, tdc_valid, out_tick};
  int                           miscompares = 0;
  int                           n_checks = 0;
  pcc_src_model src (.mclk(mclk), .xo_run(xo_run), .lock_ok(1'b1),
    .xo_in(xo_in), .ref_in(ref_in), .vco_clk(vco_clk), .apll_lock_in(lock_in));
  pcc_top uut (.mclk(mclk), .rst(rst), .ce(ce), .xo_in(xo_in), .ref_in(ref_in),
    .vco_clk(vco_clk), .apll_lock_in(lock_in), .apll_cfg(acfg),
    .out_cfg(ocfg), .dpll_cfg(dcfg), .out_tick(out_tick),
    .out_muted(out_muted), .apll_ready(apll_ready), .apll_pfd_tick(pfd),
    .apll_fb_tick(fbt), .sdm_num(sdm_num), .tdc_word(tdc_word),
    .tdc_valid(tdc_valid), .dpll_fb_tick(dfb), .xo_detected());

  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;

  task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  // Gap before the third pulse; the first gaps may span a config change.
  task automatic per(int b, output int p);
    for (int k = 0; k < 3; k++) begin
      p = 0;
      do begin @(negedge mclk); p++; end while (probe[b] !== 1'b1 && p < 20000);
    end
  endtask
  task automatic oc(int i, pcc_pkg::pcc_src_t s, int d, bit b, int sd);
    ocfg[i].src = s;
    ocfg[i].output_channel_divider = 12'(d);
    ocfg[i].bypass = b;
    ocfg[i].sysref_en = sd != 0;
    ocfg[i].sysref_div = 20'(sd);
  endtask
  task automatic wait_ready(output int c);
    c = 0;
    while (apll_ready !== 3'h7 && c < 4000) begin @(negedge mclk); c++; end
  endtask
  task automatic t_cal;
    int c;
    chk("muted", 16'hFFFF, out_muted);
    repeat (3000) @(negedge mclk);
    chk("ready", 3'h0, apll_ready);
    chk("muted", 16'h0041, out_muted);
    xo_run = 1'b1;
    wait_ready(c);
    chk("cal", 1, c >= 2500 && c < 2600);
    @(negedge mclk);
    chk("muted", 16'h0000, out_muted);
    $display("t_cal done");
  endtask
  task automatic t_div;
    int ch[7] = '{0, 1, 4, 6, 10, 2, 8};
    int ep[7] = '{24, 28, 12, 52, 24, 56, 16380};
    int p;
    logic [15:0] seen;
    acfg[0].primary_post_divider = 4'h3;
    acfg[0].secondary_post_divider = 4'h7;
    acfg[1].primary_post_divider = 4'hD;
    acfg[1].secondary_post_divider = 4'h9;
    acfg[2].primary_post_divider = 4'h1;
    oc(0, pcc_pkg::SRC_A1P1, 2, 0, 0);
    oc(1, pcc_pkg::SRC_A1P2, 1, 0, 0);
    oc(4, pcc_pkg::SRC_A2P2, 5, 1, 0);
    oc(6, pcc_pkg::SRC_A2P1, 1, 0, 0);
    oc(10, pcc_pkg::SRC_A3, 3, 0, 2);
    oc(2, pcc_pkg::SRC_A1P2, 2, 0, 5);
    oc(8, pcc_pkg::SRC_A3, 4095, 0, 0);
    oc(3, pcc_pkg::SRC_A3, 0, 0, 0);
    oc(5, pcc_pkg::SRC_A1P2, 0, 0, 0);
    oc(7, pcc_pkg::SRC_A2P2, 0, 0, 0);
    oc(13, pcc_pkg::SRC_A3, 0, 0, 0);
    oc(14, pcc_pkg::SRC_A1P2, 0, 0, 0);
    repeat (10) @(negedge mclk);
    seen = '0;
    repeat (200) begin @(negedge mclk); seen |= out_tick; end
    chk("route", 16'hA000, seen & 16'hE2A8);
    for (int j = 0; j < 7; j++) begin
      per(ch[j], p);
      chk("period", ep[j], p);
    end
    $display("t_div done");
  endtask
  task automatic t_recal;
    int c;
    acfg[1].analog_loop_enable = 1'b0;
    repeat (4) @(negedge mclk);
    chk("ready", 3'h5, apll_ready);
    chk("mute6", 1'b1, out_muted[6]);
    acfg[1].analog_loop_enable = 1'b1;
    wait_ready(c);
    chk("recal", 1, c >= 2500 && c < 2600);
    $display("t_recal done");
  endtask

  task automatic t_dpll;
    int p;
    logic [15:0] w;
    per(17, p);
    chk("fb", 20, p);
    dcfg.feedback_setting_select[0] = 1'b1;
    per(17, p);
    chk("fb", 28, p);
    dcfg.ref_sel = 1'b1;
    per(17, p);
    chk("fb", 20, p);
    per(19, p);
    chk("afb", 20, p);
    acfg[0].r_div = 5'h03;
    acfg[0].dbl_en = 1'b1;
    per(21, p);
    chk("pfd", 12, p);
    // A top-size feedback count keeps the phase word free of fb steps.
    dcfg.fb_int[0] = 33'h1_FFFF_FFFF;
    dcfg.fb_int[1] = 33'h1_FFFF_FFFF;
    repeat (60) @(negedge mclk);
    per(16, p);
    chk("tdc_rate", 24, p);
    w = tdc_word;
    per(16, p);
    chk("tdc", w + 16'h0003, tdc_word);
    repeat (2) @(negedge mclk);
    chk("sdm", 40'(acfg[0].n_num + {{24{tdc_word[15]}}, tdc_word}), sdm_num[0]);
    ce = 1'b0;
    w = tdc_word;
    repeat (40) @(negedge mclk);
    chk("held", w, tdc_word);
    ce = 1'b1;
    $display("t_dpll done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Static plan: fixed denominator on the steered loop, two fb settings.
  initial begin
    acfg = '0;
    ocfg = '0;
    dcfg = '0;
    for (int k = 0; k < 3; k++) begin
      acfg[k].analog_loop_enable = 1'b1;
      acfg[k].n_int = 12'h005;
      acfg[k].primary_post_divider = 4'h2;
      acfg[k].secondary_post_divider = 4'h2;
    end
    acfg[0].dpll_steer = 1'b1;
    acfg[0].n_num = 40'h12_3456_789A;
    ocfg[0].mute_en = 1'b1;
    ocfg[6].mute_en = 1'b1;
    dcfg.fb_int[0] = 33'h0_0000_0005;
    dcfg.fb_int[1] = 33'h0_0000_0007;
    dcfg.ref_div[0] = 16'h0003;
    dcfg.ref_div[1] = 16'h0004;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    t_cal;
    t_div;
    t_recal;
    t_dpll;
    summarize;
  end

  // Watchdog at about one and a half times the expected run.
  initial begin
    #3_600_000;
    miscompares++;
    summarize;
  end
endmodule
